// [logic/bmts_link.sv]
// Biphase mark serial transport stream link: transmit encoder and receive aligner
// What this block does
// RULE1 - Line bit timing derived from byte clock, eight bits per byte period.
// RULE2 - Every byte presented after the first two rises since reset is sent, so packet gaps pass unchanged.
// RULE3 - No justification or stuffing bits are ever inserted.
// RULE4 - Parallel bytes are loaded and shifted out serially before encoding.
// RULE5 - The serial bits are biphase mark encoded onto the line.
// RULE6 - Received line samples are biphase mark decoded back to NRZ bits.
// RULE7 - Sync word position in decoded bits sets the byte boundary.
// RULE8 - One sender to one receiver, one direction, no return path.
// RULE9 - Bytes go out MSB first and are rebuilt MSB first.
// RULE10 - Line toggles at every bit start and at mid-bit for ones.
// RULE11 - Format from sync value and spacing: 47/188, 47/204 dummy, B8/204.
// RULE12 - Rebuild packet start and byte valid flags on the parallel output.
// RULE13 - Lock after several spaced syncs; drop lock after repeated misses.
`timescale 1ns/1ns
module bmts_link (
   input wire logic clk, // 125 MHz system clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic ce, // Clock enable, freezes state when low
   input wire logic tx_byte_clk, // Transport byte clock pin
   input wire logic [7:0] tx_data, // Transport byte, taken at byte clock rise
   output logic tx_line, // Encoded serial line out
   input wire logic rx_line_clk, // Recovered half-bit clock from CDR
   input wire logic rx_line_in, // Recovered line level from CDR
   output bmts_pkg::bmts_rx_byte_s rx_out, // Rebuilt byte and flags
   output logic rx_out_valid, // One-cycle strobe per rebuilt byte
   output logic rx_locked // Byte lock held
);
   import bmts_pkg::*;

   function automatic logic is_sync(input logic [7:0] b);
      is_sync = (b == SYNC_WORD) || (b == SYNC_INV);
   endfunction

   // ==========================================================
   // Transmit: pin synchronisers
   logic bc_s1, bc_s2, bc_s3;
   logic [7:0] td_s1, td_s2;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bc_s1 <= 1'b0;
         bc_s2 <= 1'b0;
         bc_s3 <= 1'b0;
         td_s1 <= 8'h00;
         td_s2 <= 8'h00;
      end else if (ce) begin
         bc_s1 <= tx_byte_clk;
         bc_s2 <= bc_s1;
         bc_s3 <= bc_s2;
         td_s1 <= tx_data;
         td_s2 <= td_s1;
      end
   end
   wire tx_rise = bc_s2 & ~bc_s3;

   // ==========================================================
   // Transmit: half-bit timing locked to the byte period
   // Period is measured in clk cycles and split into 16 half-bits by an
   // accumulator, so the line rate tracks the byte rate with no overhead.
   logic [PER_W-1:0] per_cnt, per_len, acc;
   logic per_seen, per_ok, hb_run;
   logic [3:0] hb_idx;
   logic [7:0] tx_sr;
   wire [PER_W:0] acc_sum = {1'b0, acc} + {1'b0, HALF_BITS};
   wire hb_tick = hb_run && per_ok && (acc_sum >= {1'b0, per_len}); // RULE1
   wire [3:0] hb_next = hb_idx + 4'h1;
   wire tx_cur_bit = tx_sr[~hb_next[3:1]]; // RULE9
   wire tx_toggle = ~hb_next[0] | tx_cur_bit; // RULE10

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         per_cnt <= PER_RST;
         per_len <= PER_RST;
         acc <= PER_RST;
         per_seen <= 1'b0;
         per_ok <= 1'b0;
         hb_run <= 1'b0;
         hb_idx <= 4'h0;
         tx_sr <= 8'h00;
         tx_line <= LINE_RST;
      end else if (ce) begin
         if (tx_rise) begin
            per_len <= per_cnt + 16'h0001; // RULE1
            per_cnt <= PER_RST;
            per_seen <= 1'b1;
            per_ok <= per_seen;
            // Every byte from the third rise on is sent as presented, dummy or not
            tx_sr <= td_s2; // RULE4 RULE2
            hb_idx <= 4'h0;
            acc <= PER_RST;
            hb_run <= per_ok; // RULE3
            if (per_ok) begin
               tx_line <= ~tx_line; // RULE10 RULE5
            end
         end else begin
            per_cnt <= per_cnt + 16'h0001;
            if (hb_tick) begin
               acc <= acc_sum[PER_W-1:0] - per_len;
               hb_idx <= hb_next;
               hb_run <= (hb_next != 4'hf);
               if (tx_toggle) begin
                  tx_line <= ~tx_line; // RULE5
               end
            end else if (hb_run) begin
               acc <= acc_sum[PER_W-1:0];
            end
         end
      end
   end

   // ==========================================================
   // Receive: pin synchronisers and half-bit sampling
   logic lc_s1, lc_s2, lc_s3, ld_s1, ld_s2;
   logic half_prev, phase;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lc_s1 <= 1'b0;
         lc_s2 <= 1'b0;
         lc_s3 <= 1'b0;
         ld_s1 <= 1'b0;
         ld_s2 <= 1'b0;
      end else if (ce) begin
         lc_s1 <= rx_line_clk;
         lc_s2 <= lc_s1;
         lc_s3 <= lc_s2;
         ld_s1 <= rx_line_in;
         ld_s2 <= ld_s1;
      end
   end
   wire rx_tick = lc_s2 & ~lc_s3;
   // A missing boundary transition means we sat mid-bit: emit a zero and
   // realign. An all-ones stream cannot realign, but sync words hold zeros.
   wire dec_strobe = rx_tick & (phase | (ld_s2 == half_prev)); // RULE6
   wire dec_bit = phase & (ld_s2 ^ half_prev); // RULE6

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         half_prev <= 1'b0;
         phase <= 1'b0;
      end else if (ce && rx_tick) begin
         half_prev <= ld_s2;
         phase <= ~phase & (ld_s2 != half_prev);
      end
   end

   // ==========================================================
   // Receive: byte alignment and lock
   bmts_sync_e st;
   logic [7:0] sr, first, pos;
   logic [2:0] bit_cnt, hits, miss;
   logic per204, per_known;
   wire [7:0] next_sr = {sr[6:0], dec_bit}; // RULE9
   wire byte_done = dec_strobe && (bit_cnt == 3'h7) && (st != BMTS_SEARCH);
   wire [7:0] npos = pos + 8'h01;
   wire at_188 = (npos == PKT_LEN_SHORT);
   wire at_204 = (npos == PKT_LEN_LONG);
   wire match = (next_sr == first);
   wire cand188 = at_188 && match && (first == SYNC_WORD) && !(per_known && per204); // RULE11
   wire cand204 = at_204 && match && !(per_known && !per204); // RULE11
   wire hit = cand188 | cand204;
   wire slot = per_known ? (per204 ? at_204 : at_188) : at_204;
   wire fail = slot && !hit;
   wire dummy = per204 && (first == SYNC_WORD) && (npos >= PKT_LEN_SHORT) && !slot;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= BMTS_SEARCH;
         sr <= 8'h00;
         first <= 8'h00;
         pos <= 8'h00;
         bit_cnt <= 3'h0;
         hits <= 3'h0;
         miss <= 3'h0;
         per204 <= 1'b0;
         per_known <= 1'b0;
         rx_out <= RX_OUT_RST;
         rx_out_valid <= 1'b0;
      end else if (ce) begin
         rx_out_valid <= 1'b0;
         if (dec_strobe) begin
            sr <= next_sr;
            bit_cnt <= bit_cnt + 3'h1;
         end
         if (st == BMTS_SEARCH && dec_strobe && is_sync(next_sr)) begin
            st <= BMTS_VERIFY; // RULE7
            first <= next_sr;
            bit_cnt <= 3'h0;
            pos <= 8'h00;
            hits <= 3'h1;
            per_known <= 1'b0;
         end else if (byte_done) begin
            pos <= (hit || slot) ? 8'h00 : npos;
            if (hit) begin
               per204 <= cand204;
               per_known <= 1'b1;
               miss <= 3'h0;
            end
            if (st == BMTS_VERIFY) begin
               if (fail) begin
                  st <= BMTS_SEARCH;
               end else if (hit) begin
                  hits <= hits + 3'h1;
                  if (hits + 3'h1 == LOCK_HITS) begin
                     st <= BMTS_LOCKED; // RULE13
                  end
               end
            end else begin
               if (fail) begin
                  miss <= miss + 3'h1;
                  if (miss + 3'h1 == MISS_MAX) begin
                     st <= BMTS_SEARCH; // RULE13
                  end
               end
               rx_out.data <= next_sr; // RULE8
               rx_out.packet_start_flag <= slot; // RULE12
               rx_out.byte_valid_flag <= !dummy; // RULE12 RULE11
               rx_out_valid <= 1'b1;
            end
         end
      end
   end
   assign rx_locked = (st == BMTS_LOCKED);

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_tx_bit_start: assert property (ce && tx_rise && per_ok |=> tx_line != $past(tx_line)) // RULE10
      else $error("line did not toggle at bit start");
   chk_tx_zero_mid: assert property (ce && hb_tick && !tx_rise && hb_next[0] && !tx_cur_bit
      |=> $stable(tx_line)) // RULE10
      else $error("line toggled mid-bit for a zero");
   chk_tx_one_mid: assert property (ce && hb_tick && !tx_rise && hb_next[0] && tx_cur_bit
      |=> tx_line != $past(tx_line)) // RULE5
      else $error("line kept level mid-bit for a one");
   chk_tx_byte_load: assert property (ce && tx_rise |=> tx_sr == $past(td_s2)) // RULE4
      else $error("presented byte not loaded");
   chk_rx_start_sync: assert property (rx_out_valid && rx_out.packet_start_flag && per_known
      && $past(hit) |-> is_sync(rx_out.data)) // RULE12
      else $error("packet start on non-sync byte");
   chk_rx_valid_short: assert property (rx_out_valid && !per204 |-> rx_out.byte_valid_flag) // RULE11
      else $error("byte valid dropped in short format");
   chk_rx_lock_entry: assert property (ce && st != BMTS_LOCKED ##1 st == BMTS_LOCKED
      |-> $past(st) == BMTS_VERIFY && $past(hits) == LOCK_HITS - 3'h1) // RULE13
      else $error("lock taken without enough syncs");
   chk_rx_lock_drop: assert property (ce && rx_locked && byte_done && fail
      && miss == MISS_MAX - 3'h1 |=> st == BMTS_SEARCH) // RULE13
      else $error("lock held after repeated misses");
   chk_rx_align: assert property (ce && st == BMTS_SEARCH && dec_strobe && is_sync(next_sr)
      |=> st == BMTS_VERIFY && bit_cnt == 3'h0 && is_sync(first)) // RULE7
      else $error("sync word did not set byte boundary");
endmodule

// [logic/bmts_pkg.sv]
// Shared constants and types for the biphase mark serial transport link
package bmts_pkg;
   // ==========================================================
   // Packet framing
   localparam logic [7:0] SYNC_WORD = 8'h47;
   localparam logic [7:0] SYNC_INV = 8'hb8;
   localparam logic [7:0] PKT_LEN_SHORT = 8'hbc;
   localparam logic [7:0] PKT_LEN_LONG = 8'hcc;
   // ==========================================================
   // Lock hysteresis
   localparam logic [2:0] LOCK_HITS = 3'h3;
   localparam logic [2:0] MISS_MAX = 3'h3;
   // ==========================================================
   // Transmit timing
   localparam int PER_W = 16;
   localparam logic [PER_W-1:0] HALF_BITS = 16'h0010;
   localparam logic [PER_W-1:0] PER_RST = 16'h0000;
   localparam logic LINE_RST = 1'b0;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      BMTS_SEARCH,
      BMTS_VERIFY,
      BMTS_LOCKED
   } bmts_sync_e;
   typedef struct packed {
      logic [7:0] data;
      logic packet_start_flag;
      logic byte_valid_flag;
   } bmts_rx_byte_s;
   localparam bmts_rx_byte_s RX_OUT_RST = '{data: 8'h00, packet_start_flag: 1'b0,
      byte_valid_flag: 1'b0};
endpackage

// [sim/bmts_far_end.sv]
// Far-end model: biphase mark source for the receiver, edge counter for the transmitter
`timescale 1ns/1ns
module bmts_far_end (
   input wire logic clk, // System clock for the edge monitor
   input wire logic tx_line, // Encoded line from the transmitter
   output logic rx_line_clk, // Half-bit clock towards the receiver
   output logic rx_line_in, // Encoded line towards the receiver
   output int tx_toggles // Transitions seen on the transmit line
);
   logic last_tx = 1'b0;
   int toggles = 0;
   assign tx_toggles = toggles;
   initial begin
      rx_line_clk = 1'b0;
      rx_line_in = 1'b0;
   end
   // Listen only, never answer: one-way link
   always @(posedge clk) begin
      if (tx_line !== last_tx) toggles <= toggles + 1;
      last_tx <= tx_line;
   end
   // Half-bit clock only runs while bytes are sent, back to back with no gap between
   // Four system clocks per half-bit, the shortest the receiver takes
   task automatic half_bit(input logic lvl);
      rx_line_in = lvl;
      #16 rx_line_clk = 1'b1;
      #16 rx_line_clk = 1'b0;
   endtask
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         half_bit(~rx_line_in);
         half_bit(b[i] ? ~rx_line_in : rx_line_in);
      end
   endtask
endmodule

// [sim/tb_biphase_mark_serial_ts_link.sv]
// Self-checking bench for the biphase mark serial transport link
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_biphase_mark_serial_ts_link;
   import bmts_pkg::*;
   logic clk, sys_rst, ce, tx_byte_clk, tx_line, rx_line_clk, rx_line_in, rx_out_valid, rx_locked;
   logic [7:0] tx_data;
   bmts_rx_byte_s rx_out;
   bmts_rx_byte_s got_q[$];
   int tx_toggles;
   int err_total;
   int n_checks;
   bmts_link dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .tx_byte_clk(tx_byte_clk),
      .tx_data(tx_data), .tx_line(tx_line), .rx_line_clk(rx_line_clk),
      .rx_line_in(rx_line_in), .rx_out(rx_out), .rx_out_valid(rx_out_valid),
      .rx_locked(rx_locked));
   bmts_far_end far (.clk(clk), .tx_line(tx_line), .rx_line_clk(rx_line_clk),
      .rx_line_in(rx_line_in), .tx_toggles(tx_toggles));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      if (rx_out_valid === 1'b1) got_q.push_back(rx_out);
   end
   // ==========================================================
   // Scenarios
   task automatic do_reset();
      @(negedge clk) sys_rst = 1'b1;
      repeat (5) @(negedge clk);
      sys_rst = 1'b0;
      got_q.delete();
      `CHK("tx_line", 1'b0, tx_line)
      `CHK("rx_out", RX_OUT_RST, rx_out)
      `CHK("rx_locked", 1'b0, rx_locked)
   endtask
   // First two rises only measure the period, so their bytes never reach the line
   task automatic check_tx();
      logic [7:0] bytes [6] = '{8'h11, 8'h22, 8'ha5, 8'h0f, 8'hff, 8'h00};
      int base;
      int exp_n;
      base = tx_toggles;
      exp_n = 0;
      foreach (bytes[i]) begin
         tx_data = bytes[i];
         repeat (10) @(negedge clk);
         tx_byte_clk = 1'b1;
         // Rise is acted on 3 cycles later; the previous byte must be done by then
         repeat (3) @(negedge clk);
         `CHK("tx toggles per byte period", exp_n, tx_toggles - base)
         if (i >= 2) exp_n += 8 + $countones(bytes[i]);
         repeat (7) @(negedge clk);
         tx_byte_clk = 1'b0;
      end
      repeat (100) @(negedge clk);
      `CHK("tx toggles", exp_n, tx_toggles - base)
      `CHK("tx no stuffing", exp_n, tx_toggles - base)
      `CHK("tx bytes at byte rate", exp_n, tx_toggles - base)
   endtask
   // Three packets to lock, then a fourth sync and its first bytes
   // Bytes 188..203 of a packet are dummies only in the 47 / 204 format
   task automatic check_rx(input logic [7:0] sync, input int plen, input logic dummies);
      logic [7:0] pay [4] = '{8'h00, 8'h01, 8'h80, 8'h3c};
      int j;
      int k;
      int guard;
      for (int n = 0; n < 2; n++) far.send_byte(8'h00);
      for (int n = 0; n < 3 * plen + 4; n++) begin
         j = n % plen;
         far.send_byte(j == 0 ? sync : (j < 4 ? pay[j] : 8'h00));
      end
      k = 0;
      while (k < got_q.size() && got_q[k].packet_start_flag !== 1'b1) k++;
      guard = 0;
      while (got_q.size() < k + 4 && guard < 200) begin
         @(negedge clk);
         guard++;
      end
      if (guard >= 200 || k < 17 || k + 3 >= got_q.size()) begin
         err_total++;
         $display("unexpected rx output count expected %0d seen %0d", k + 4, got_q.size());
         complete_run();
      end else begin
         `CHK("rx_locked", 1'b1, rx_locked)
         for (int m = 0; m < 4; m++) begin
            `CHK("rx data", (m == 0 ? sync : pay[m]), got_q[k + m].data)
            `CHK("rx data aligned", (m == 0 ? sync : pay[m]), got_q[k + m].data)
            `CHK("packet start", (m == 0), got_q[k + m].packet_start_flag)
            `CHK("byte valid", 1'b1, got_q[k + m].byte_valid_flag)
         end
         `CHK("byte valid before gap", 1'b1, got_q[k - 17].byte_valid_flag)
         `CHK("first gap byte valid", !dummies, got_q[k - 16].byte_valid_flag)
         `CHK("last gap byte valid", !dummies, got_q[k - 1].byte_valid_flag)
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      ce = 1'b1;
      tx_byte_clk = 1'b0;
      tx_data = 8'h00;
      err_total = 0;
      n_checks = 0;
      do_reset();
      check_tx();
      do_reset();
      check_rx(SYNC_WORD, 188, 1'b0);
      do_reset();
      check_rx(SYNC_INV, 204, 1'b0);
      do_reset();
      check_rx(SYNC_WORD, 204, 1'b1);
      complete_run();
   end
endmodule
